// file: hdl/ipu_pkg.sv
// constants, register map and types of the interrupt enable and priority unit
// assumes one core clock domain and a 32-bit Avalon-MM register port

package ipu_pkg;
	// ***************************************************************
	// sources and levels
	// ***************************************************************
	localparam int IPU_NSRC = 6;
	localparam int IPU_IDX_W = 3;
	localparam int IPU_NLVL = 4;
	localparam int IPU_LVL_W = 2;
	// source index equals enable/priority bit and polling order
	localparam int IPU_SRC_EXT0 = 0;
	localparam int IPU_SRC_TIMER0 = 1;
	localparam int IPU_SRC_EXT1 = 2;
	localparam int IPU_SRC_TIMER1 = 3;
	localparam int IPU_SRC_SERIAL = 4;
	localparam int IPU_SRC_TIMER2 = 5;
	localparam int IPU_GATE_BIT = 7;
	localparam logic [IPU_NSRC-1:0][7:0] IPU_VECTORS = {
		8'h2b, 8'h23, 8'h1b, 8'h13, 8'h0b, 8'h03};

	// ***************************************************************
	// register map: word index, byte address is four times it
	// ***************************************************************
	localparam int IPU_ADDR_W = 10;
	localparam logic [7:0] IPU_IDX_ENABLE = 8'ha8;
	localparam logic [7:0] IPU_IDX_PRIO_HI = 8'hb7;
	localparam logic [7:0] IPU_IDX_PRIO_LO = 8'hb8;
	localparam logic [7:0] IPU_IDX_STATUS = 8'hc0;
	localparam logic [7:0] IPU_IDX_MASK = 8'hc1;
	localparam logic [7:0] IPU_ENABLE_IMPL = 8'hbf;
	localparam logic [7:0] IPU_PRIO_IMPL = 8'h3f;
	localparam logic [7:0] IPU_ENABLE_RST = 8'h00;
	localparam logic [7:0] IPU_PRIO_RST = 8'h00;

	// ***************************************************************
	// status events
	// ***************************************************************
	localparam int IPU_NEVT = 3;
	localparam int IPU_EVT_TAKEN = 0;
	localparam int IPU_EVT_NESTED = 1;
	localparam int IPU_EVT_BADRET = 2;
	localparam logic [IPU_NEVT-1:0] IPU_MASK_RST = 3'h0;

	typedef enum logic [1:0] {
		IPU_BUS_IDLE = 2'b01,
		IPU_BUS_ANSWER = 2'b10
	} ipu_bus_state_t;
endpackage

// file: hdl/ipu_prio_select.sv
// winner selection among eligible sources by level, then polling order
// assumes eligibility already gated by the enables; purely combinational
`timescale 1ns/1ps

module ipu_prio_select #(
	parameter int NSRC = ipu_pkg::IPU_NSRC
) (
	input wire logic [NSRC-1:0] elig,
	input wire logic [NSRC-1:0] prioHi,
	input wire logic [NSRC-1:0] prioLo,
	output logic anyWin,
	output logic [ipu_pkg::IPU_IDX_W-1:0] winIdx,
	output logic [ipu_pkg::IPU_LVL_W-1:0] winLevel
);
	logic [ipu_pkg::IPU_LVL_W-1:0] srcLevel [NSRC];

	// ***************************************************************
	// per-source level from the bit pair
	// ***************************************************************
	genvar k;
	generate
		for (k = 0; k < NSRC; k++) begin : g_lvl
			assign srcLevel[k] = {prioHi[k], prioLo[k]}; // [R11] [R12]
		end
	endgenerate

	// scan from last in polling order so the earlier source wins a tie
	always_comb begin
		anyWin = 1'b0;
		winIdx = '0;
		winLevel = '0;
		for (int i = NSRC - 1; i >= 0; i--) begin
			if (elig[i] && (!anyWin || srcLevel[i] >= winLevel)) begin // [R13]
				anyWin = 1'b1;
				winIdx = ipu_pkg::IPU_IDX_W'(i);
				winLevel = srcLevel[i];
			end
		end
	end
endmodule

// file: hdl/ipu_event_status.sv
// sticky event status with read clear, mask and one level interrupt
// assumes event pulses and the read clear are in the sys_clk domain
`timescale 1ns/1ps

module ipu_event_status #(
	parameter int NEVT = ipu_pkg::IPU_NEVT
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [NEVT-1:0] evtPulse,
	input wire logic readClear,
	input wire logic [NEVT-1:0] evtMask,
	output logic [NEVT-1:0] status,
	output logic irqOut
);
	// an event in the clearing cycle survives the clear
	wire [NEVT-1:0] next_status = (status & ~{NEVT{readClear}}) | evtPulse;

	// status and interrupt level, both registered
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			status <= '0;
			irqOut <= 1'b0;
		end else begin
			status <= next_status;
			irqOut <= |(next_status & evtMask);
		end
	end
endmodule

// file: hdl/ipu_top.sv
// interrupt enable and priority unit: registers, gating, selection, nesting
// assumes sources hold requests as levels and the core pulses ack and return
//
// How it works
// [R1] gate bit 7 low blocks every request; high lets each enable decide
// [R2] enable bit 5 passes or blocks the timer 2 request
// [R3] enable bit 4 passes or blocks the serial port request
// [R4] enable bit 3 passes or blocks the timer 1 request
// [R5] enable bit 2 passes or blocks the external 1 request
// [R6] enable bit 1 passes or blocks the timer 0 request
// [R7] enable bit 0 passes or blocks the external 0 request
// [R8] unimplemented bits are not stored; software must write them as zero
// [R9] low priority register bits 5..0: timer2, serial, timer1, ext1, timer0, ext0
// [R10] high priority register uses the same bit order as the low one
// [R11] a source's level pairs its high bit with its low bit
// [R12] pair 00 is level 0 lowest up to 11 level 3 highest
// [R13] equal levels resolve by polling order; vectors 03h to 2Bh step 8
// [R14] only a strictly higher level preempts a running handler
//
// Register access over Avalon-MM was decided locally.
`timescale 1ns/1ps

module ipu_top #(
	parameter int NSRC = ipu_pkg::IPU_NSRC
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [ipu_pkg::IPU_ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic irq,
	input wire logic [NSRC-1:0] srcReq,
	input wire logic coreAck,
	input wire logic coreReturn,
	output logic coreIrqReq,
	output logic [7:0] coreIrqVector,
	output logic [ipu_pkg::IPU_LVL_W-1:0] coreIrqLevel,
	output logic [ipu_pkg::IPU_NLVL-1:0] activeLevels
);
	// ***************************************************************
	// declarations
	// ***************************************************************
	ipu_pkg::ipu_bus_state_t busState;
	logic [7:0] enReg;
	logic [7:0] prioHiReg;
	logic [7:0] prioLoReg;
	logic [ipu_pkg::IPU_NEVT-1:0] evtMask;
	logic [ipu_pkg::IPU_NEVT-1:0] evtStatus;
	logic [ipu_pkg::IPU_IDX_W-1:0] reqIdx;
	logic [NSRC-1:0] elig;
	logic anyWin;
	logic [ipu_pkg::IPU_IDX_W-1:0] winIdx;
	logic [ipu_pkg::IPU_LVL_W-1:0] winLevel;
	logic intrLevel;

	// ***************************************************************
	// register bus decode
	// ***************************************************************
	wire [7:0] wordIdx = avs_address[ipu_pkg::IPU_ADDR_W-1:2];
	wire selEnable = (wordIdx == ipu_pkg::IPU_IDX_ENABLE);
	wire selPrioHi = (wordIdx == ipu_pkg::IPU_IDX_PRIO_HI);
	wire selPrioLo = (wordIdx == ipu_pkg::IPU_IDX_PRIO_LO);
	wire selStatus = (wordIdx == ipu_pkg::IPU_IDX_STATUS);
	wire selMask = (wordIdx == ipu_pkg::IPU_IDX_MASK);
	wire busReq = avs_read || avs_write;
	wire inIdle = (busState == ipu_pkg::IPU_BUS_IDLE);
	wire inAnswer = (busState == ipu_pkg::IPU_BUS_ANSWER);
	// writes land on the edge that sees waitrequest low
	wire wrLane = inAnswer && avs_write && avs_byteenable[0];
	wire wrEnable = wrLane && selEnable;
	wire wrPrioHi = wrLane && selPrioHi;
	wire wrPrioLo = wrLane && selPrioLo;
	wire wrMask = wrLane && selMask;
	// clear on capture so no event slips between capture and clear
	wire readClear = inIdle && avs_read && selStatus;
	wire [7:0] statusByte = 8'(evtStatus);
	wire [7:0] maskByte = 8'(evtMask);
	// unmapped words read zero
	wire [7:0] rdMux = selEnable ? enReg :
		selPrioHi ? prioHiReg :
		selPrioLo ? prioLoReg :
		selStatus ? statusByte :
		selMask ? maskByte : 8'h00;

	// ***************************************************************
	// bus handshake: one wait cycle, then one answer cycle
	// ***************************************************************
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			busState <= ipu_pkg::IPU_BUS_IDLE;
			avs_waitrequest <= 1'b1;
			avs_readdata <= '0;
		end else begin
			case (busState)
				ipu_pkg::IPU_BUS_IDLE: begin
					if (busReq) begin
						busState <= ipu_pkg::IPU_BUS_ANSWER;
						avs_waitrequest <= 1'b0;
						avs_readdata <= {24'h000000, rdMux};
					end
				end
				ipu_pkg::IPU_BUS_ANSWER: begin
					busState <= ipu_pkg::IPU_BUS_IDLE;
					avs_waitrequest <= 1'b1;
				end
				default: begin
					busState <= ipu_pkg::IPU_BUS_IDLE;
					avs_waitrequest <= 1'b1;
				end
			endcase
		end
	end

	// ***************************************************************
	// software registers
	// ***************************************************************
	// reserved bits are dropped, so they always read zero
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			enReg <= ipu_pkg::IPU_ENABLE_RST;
			prioHiReg <= ipu_pkg::IPU_PRIO_RST;
			prioLoReg <= ipu_pkg::IPU_PRIO_RST;
			evtMask <= ipu_pkg::IPU_MASK_RST;
		end else begin
			if (wrEnable)
				enReg <= avs_writedata[7:0] & ipu_pkg::IPU_ENABLE_IMPL; // [R8]
			if (wrPrioHi)
				prioHiReg <= avs_writedata[7:0] & ipu_pkg::IPU_PRIO_IMPL; // [R10] [R8]
			if (wrPrioLo)
				prioLoReg <= avs_writedata[7:0] & ipu_pkg::IPU_PRIO_IMPL; // [R9] [R8]
			if (wrMask)
				evtMask <= avs_writedata[ipu_pkg::IPU_NEVT-1:0];
		end
	end

	// ***************************************************************
	// gating and selection
	// ***************************************************************
	wire gateOpen = enReg[ipu_pkg::IPU_GATE_BIT]; // [R1]
	genvar k;
	generate
		for (k = 0; k < NSRC; k++) begin : g_gate
			// enable bit k gates source k
			assign elig[k] = gateOpen && enReg[k] && srcReq[k]; // [R2] [R3] [R4] [R5] [R6] [R7]
		end
	endgenerate

	ipu_prio_select #(
		.NSRC(NSRC)
	) u_select (
		.elig(elig),
		.prioHi(prioHiReg[NSRC-1:0]),
		.prioLo(prioLoReg[NSRC-1:0]),
		.anyWin(anyWin),
		.winIdx(winIdx),
		.winLevel(winLevel)
	);

	// ***************************************************************
	// handler nesting: one in-service bit per level
	// ***************************************************************
	wire anyActive = |activeLevels;
	wire [ipu_pkg::IPU_LVL_W-1:0] curLevel = activeLevels[3] ? 2'h3 :
		activeLevels[2] ? 2'h2 :
		activeLevels[1] ? 2'h1 : 2'h0;
	wire ackTake = coreAck && coreIrqReq;
	wire doPop = coreReturn && anyActive;
	wire [ipu_pkg::IPU_NLVL-1:0] popMask = doPop ? 4'(4'h1 << curLevel) : 4'h0;
	wire [ipu_pkg::IPU_NLVL-1:0] pushMask = ackTake ? 4'(4'h1 << coreIrqLevel) : 4'h0;
	wire [ipu_pkg::IPU_NLVL-1:0] next_active = (activeLevels & ~popMask) | pushMask; // [R14]
	// strictly higher level only; ack cycle masked so a taken request is not repeated
	wire preemptOk = !anyActive || (winLevel > curLevel); // [R14]
	wire next_req = anyWin && preemptOk && !ackTake;

	// in-service levels and the registered request to the core
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			activeLevels <= '0;
			coreIrqReq <= 1'b0;
			coreIrqVector <= '0;
			coreIrqLevel <= '0;
			reqIdx <= '0;
		end else begin
			activeLevels <= next_active;
			coreIrqReq <= next_req;
			coreIrqVector <= ipu_pkg::IPU_VECTORS[winIdx]; // [R13]
			coreIrqLevel <= winLevel; // [R12]
			reqIdx <= winIdx;
		end
	end

	// ***************************************************************
	// events and the bus interrupt
	// ***************************************************************
	wire [ipu_pkg::IPU_NEVT-1:0] evtPulse = {coreReturn && !anyActive,
		ackTake && anyActive, ackTake};

	ipu_event_status #(
		.NEVT(ipu_pkg::IPU_NEVT)
	) u_status (
		.sys_clk(sys_clk),
		.rst(rst),
		.evtPulse(evtPulse),
		.readClear(readClear),
		.evtMask(evtMask),
		.status(evtStatus),
		.irqOut(intrLevel)
	);

	// irq itself is the flop inside the status block
	assign irq = intrLevel;

	// ***************************************************************
	// assertions
	// ***************************************************************
	property p_gate_off;
		@(posedge sys_clk) disable iff (rst)
		!enReg[ipu_pkg::IPU_GATE_BIT] |=> !coreIrqReq;
	endproperty
	a_gate_off: assert property (p_gate_off) else $error("request with gate closed"); // [R1]

	generate
		for (k = 0; k < NSRC; k++) begin : g_chk
			property p_src_block;
				@(posedge sys_clk) disable iff (rst)
				!enReg[k] |=> !(coreIrqReq && coreIrqVector == ipu_pkg::IPU_VECTORS[k]);
			endproperty
			a_src_block: assert property (p_src_block) else $error("disabled source granted"); // [R2] [R3] [R4] [R5] [R6] [R7]
		end
	endgenerate

	property p_resv_zero;
		@(posedge sys_clk) disable iff (rst)
		((enReg & ~ipu_pkg::IPU_ENABLE_IMPL) == 8'h00) &&
		(((prioHiReg | prioLoReg) & ~ipu_pkg::IPU_PRIO_IMPL) == 8'h00);
	endproperty
	a_resv_zero: assert property (p_resv_zero) else $error("reserved bit stored"); // [R8]

	property p_lo_write;
		@(posedge sys_clk) disable iff (rst)
		wrPrioLo |=> prioLoReg == ($past(avs_writedata[7:0]) & ipu_pkg::IPU_PRIO_IMPL);
	endproperty
	a_lo_write: assert property (p_lo_write) else $error("low priority write lost"); // [R9]

	property p_hi_write;
		@(posedge sys_clk) disable iff (rst)
		wrPrioHi |=> prioHiReg == ($past(avs_writedata[7:0]) & ipu_pkg::IPU_PRIO_IMPL);
	endproperty
	a_hi_write: assert property (p_hi_write) else $error("high priority write lost"); // [R10]

	property p_level_pair;
		@(posedge sys_clk) disable iff (rst)
		(coreIrqReq && $stable(prioHiReg) && $stable(prioLoReg)) |->
			coreIrqLevel == {prioHiReg[reqIdx], prioLoReg[reqIdx]};
	endproperty
	a_level_pair: assert property (p_level_pair) else $error("level not from bit pair"); // [R11] [R12]

	property p_poll_first;
		@(posedge sys_clk) disable iff (rst)
		(elig[ipu_pkg::IPU_SRC_EXT0] && prioHiReg[0] && prioLoReg[0] && !anyActive && !ackTake)
			|=> coreIrqReq && coreIrqVector == ipu_pkg::IPU_VECTORS[ipu_pkg::IPU_SRC_EXT0];
	endproperty
	a_poll_first: assert property (p_poll_first) else $error("first source lost a tie"); // [R13]

	property p_nest_higher;
		@(posedge sys_clk) disable iff (rst)
		(coreIrqReq && anyActive) |-> coreIrqLevel > curLevel;
	endproperty
	a_nest_higher: assert property (p_nest_higher) else $error("preempt at equal or lower level"); // [R14]

	property p_push_level;
		@(posedge sys_clk) disable iff (rst)
		ackTake |=> activeLevels[$past(coreIrqLevel)] ##1 !coreIrqReq || coreIrqLevel > curLevel;
	endproperty
	a_push_level: assert property (p_push_level) else $error("taken level not in service"); // [R14]
endmodule

// file: sim/ipu_core_model.sv
// core sequencer model: takes offered requests and signals handler return
// assumes the bench drives autoAck, ackDelay and retGo at rising edges
`timescale 1ns/1ps

module ipu_core_model (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic coreIrqReq,
	input wire logic autoAck,
	input wire logic [3:0] ackDelay,
	input wire logic retGo,
	output logic coreAck,
	output logic coreReturn
);
	logic [3:0] waitCnt;

	// ack after ackDelay cycles of a standing request; a slow core sees the offer withdrawn
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			waitCnt <= 4'h0;
			coreAck <= 1'b0;
			coreReturn <= 1'b0;
		end else begin
			coreAck <= 1'b0;
			coreReturn <= retGo;
			if (!coreIrqReq || coreAck) begin
				waitCnt <= 4'h0;
			end else if (autoAck) begin
				if (waitCnt >= ackDelay) begin
					coreAck <= 1'b1;
				end else begin
					waitCnt <= waitCnt + 4'h1;
				end
			end
		end
	end
endmodule

// file: sim/interrupt_enable_priority_unit_test.sv
// self-checking bench: register bus, gating, selection and nesting
// assumes the core model in ipu_core_model.sv; assertions live in the design
`timescale 1ns/1ps

module interrupt_enable_priority_unit_test;
	logic sys_clk, rst, avs_read, avs_write, avs_waitrequest, irq;
	logic coreAck, coreReturn, coreIrqReq, autoAck, retGo;
	logic [9:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic [3:0] avs_byteenable, ackDelay, activeLevels;
	logic [7:0] coreIrqVector, en, hi, lo;
	logic [1:0] coreIrqLevel;
	logic [5:0] srcReq, req;
	int errors, checks;

	ipu_top dut_u (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .irq(irq), .srcReq(srcReq), .coreAck(coreAck),
		.coreReturn(coreReturn), .coreIrqReq(coreIrqReq), .coreIrqVector(coreIrqVector),
		.coreIrqLevel(coreIrqLevel), .activeLevels(activeLevels));
	ipu_core_model core_u (.sys_clk(sys_clk), .rst(rst), .coreIrqReq(coreIrqReq),
		.autoAck(autoAck), .ackDelay(ackDelay), .retGo(retGo), .coreAck(coreAck),
		.coreReturn(coreReturn));

	// ************************************************
	// helpers
	// ************************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// one transfer; held until waitrequest is seen low at a rising edge
	task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
		input logic [3:0] be);
		@(posedge sys_clk);
		avs_address <= {idx, 2'b00};
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= {24'h0, wd};
		avs_byteenable <= be;
		// no fixed wait count: only the watchdog ends a hung transfer
		do @(posedge sys_clk);
		while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		bus(1'b1, idx, d, 4'h1);
	endtask

	task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
		bus(1'b0, idx, 8'h00, 4'h1);
		check(rd, {24'h0, exp});
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge sys_clk);
		@(negedge sys_clk);
	endtask

	task automatic ret();
		@(posedge sys_clk);
		retGo <= 1'b1;
		@(posedge sys_clk);
		retGo <= 1'b0;
		settle(3);
	endtask

	// highest level wins, ties to the lowest source index
	function automatic logic [31:0] expect_win(input logic [7:0] e, input logic [7:0] h,
		input logic [7:0] l, input logic [5:0] req);
		int w;
		logic [1:0] best;
		w = -1;
		best = 2'h0;
		for (int i = 0; i < 6; i++) begin
			if (e[7] && e[i] && req[i] && (w < 0 || {h[i], l[i]} > best)) begin
				w = i;
				best = {h[i], l[i]};
			end
		end
		return (w < 0) ? 32'h0 : {21'h0, 1'b1, best, 8'h03 + 8'(w * 8)};
	endfunction

	function automatic logic [31:0] seen_win();
		if (coreIrqReq === 1'b1) return {21'h0, 1'b1, coreIrqLevel, coreIrqVector};
		return {21'h0, coreIrqReq, 10'h0};
	endfunction

	// ************************************************
	// clock, watchdog, verdict
	// ************************************************
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	// whole run needs about a thousand cycles
	initial begin
		repeat (20000) @(posedge sys_clk);
		errors++;
		end_sim();
	end

	task automatic end_sim();
		$display("checks=%0d errors=%0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// ************************************************
	// main sequence
	// ************************************************
	initial begin
		rst <= 1'b1;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		avs_address <= '0;
		avs_writedata <= '0;
		avs_byteenable <= '0;
		srcReq <= '0;
		autoAck <= 1'b0;
		ackDelay <= '0;
		retGo <= 1'b0;
		void'($urandom(32'h814b));
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		settle(1);
		check({28'h0, activeLevels}, 32'h0);
		check({31'h0, coreIrqReq}, 32'h0);
		check({31'h0, irq}, 32'h0);
		rdchk(ipu_pkg::IPU_IDX_ENABLE, 8'h00);
		// random register sets with corner cases first; no core acks here
		for (int n = 0; n < 40; n++) begin
			en = 8'($urandom) & ipu_pkg::IPU_ENABLE_IMPL;
			hi = 8'($urandom) & ipu_pkg::IPU_PRIO_IMPL;
			lo = 8'($urandom) & ipu_pkg::IPU_PRIO_IMPL;
			req = 6'($urandom);
			if (n < 3) begin
				en = (n == 0) ? 8'h3f : (n == 1) ? 8'hbf : 8'h80;
				hi = 8'h3f;
				lo = 8'h3f;
				req = 6'h3f;
			end
			wr(ipu_pkg::IPU_IDX_ENABLE, en);
			wr(ipu_pkg::IPU_IDX_PRIO_HI, hi);
			wr(ipu_pkg::IPU_IDX_PRIO_LO, lo);
			@(posedge sys_clk);
			srcReq <= req;
			settle(2);
			check(seen_win(), expect_win(en, hi, lo, req));
			rdchk(ipu_pkg::IPU_IDX_ENABLE, en);
			rdchk(ipu_pkg::IPU_IDX_PRIO_HI, hi);
			rdchk(ipu_pkg::IPU_IDX_PRIO_LO, lo);
		end
		// a write with the low lane off must not land
		bus(1'b1, ipu_pkg::IPU_IDX_ENABLE, en ^ 8'h01, 4'h0);
		rdchk(ipu_pkg::IPU_IDX_ENABLE, en);
		// nesting: level 0 handler, level 3 preempt, then returns
		@(posedge sys_clk);
		srcReq <= 6'h00;
		wr(ipu_pkg::IPU_IDX_ENABLE, 8'hbf);
		wr(ipu_pkg::IPU_IDX_PRIO_HI, 8'h20);
		wr(ipu_pkg::IPU_IDX_PRIO_LO, 8'h20);
		rdchk(ipu_pkg::IPU_IDX_STATUS, 8'h00);
		@(posedge sys_clk);
		srcReq <= 6'h01;
		settle(2);
		check(seen_win(), 32'h0000_0403);
		@(posedge sys_clk);
		ackDelay <= 4'($urandom_range(3));
		autoAck <= 1'b1;
		settle(8);
		check({28'h0, activeLevels}, 32'h1);
		check({31'h0, coreIrqReq}, 32'h0);
		@(posedge sys_clk);
		autoAck <= 1'b0;
		srcReq <= 6'h21;
		settle(2);
		check(seen_win(), 32'h0000_072b);
		@(posedge sys_clk);
		autoAck <= 1'b1;
		settle(8);
		check({28'h0, activeLevels}, 32'h9);
		check({31'h0, coreIrqReq}, 32'h0);
		rdchk(ipu_pkg::IPU_IDX_STATUS, 8'h03);
		rdchk(ipu_pkg::IPU_IDX_STATUS, 8'h00);
		@(posedge sys_clk);
		autoAck <= 1'b0;
		srcReq <= 6'h00;
		ret();
		check({28'h0, activeLevels}, 32'h1);
		ret();
		check({28'h0, activeLevels}, 32'h0);
		wr(ipu_pkg::IPU_IDX_MASK, 8'h04);
		ret();
		check({31'h0, irq}, 32'h1);
		rdchk(ipu_pkg::IPU_IDX_STATUS, 8'h04);
		settle(1);
		check({31'h0, irq}, 32'h0);
		// reset in mid-run with a handler in service
		@(posedge sys_clk);
		autoAck <= 1'b1;
		srcReq <= 6'h01;
		settle(8);
		check({28'h0, activeLevels}, 32'h1);
		@(posedge sys_clk);
		rst <= 1'b1;
		autoAck <= 1'b0;
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		settle(1);
		check({28'h0, activeLevels}, 32'h0);
		check({31'h0, coreIrqReq}, 32'h0);
		rdchk(ipu_pkg::IPU_IDX_ENABLE, 8'h00);
		end_sim();
	end
endmodule
